//--- verilog/ulc_regs.sv
// vendor and carkit register bank of the transceiver
`default_nettype none
module ulc_regs #(
	parameter int CONV_CYCLES = ulc_pkg::CONV_CYCLES
) (
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             arst_n_in,
	// register access from the link protocol engine
	input  wire ulc_pkg::ulc_req_t req_in,
	output ulc_pkg::ulc_rsp_t      rsp_out,
	// ID pin and resistor converter
	input  wire logic             ident_open_in,     // ID pin floating
	input  wire logic [2:0]       id_resistor_code_in,
	output logic                  conv_active_out,
	// RXCMD alt_int request
	output logic                  alt_int_out,
	// analog controls
	output logic [1:0]            hs_tx_drive_boost_out,
	output logic                  headset_audio_en_out
);
	// carkit interrupt enable bits
	logic       ident_open_rise_enable_r;
	logic       ident_open_fall_enable_r;
	logic       ck_conv_irq_enable_r;
	// event latch bits
	logic       ident_open_event_latch_r;
	logic       resistor_conv_event_latch_r;
	// vendor registers
	logic [1:0] hs_tx_drive_boost_r;
	logic [3:0] headset_audio_key_r;
	logic [2:0] id_resistor_code_r;
	logic       resistor_conv_done_r;
	logic       resistor_conv_trigger_r;
	logic       conv_rsvd_r;         // stored, link keeps it zero
	logic       resistor_conv_irq_enable_r;
	// decoded access
	logic       acc_ok;               // address lies in immediate space
	logic [7:0] a;                    // effective address
	logic       wr;
	logic       rd;
	logic [7:0] wd;
	// helpers
	logic       irq_en_eff;
	logic       conv_start;
	logic       conv_done_pulse;
	logic [2:0] conv_code;
	logic       conv_run;
	logic [1:0] rise;
	logic [1:0] fall;
	logic       float_evt;
	logic       conv_evt;
	logic [7:0] conv_view;
	logic [7:0] conv_nxt;
	logic [7:0] ien_view;
	logic [7:0] ien_nxt;
	logic [7:0] rdata_nxt;
	logic       hit_nxt;

	// the protocol engine resolves extended sequences before this point,
	// so the address arrives already flattened and ext needs no decode
	// both addressing forms land in the same 00h-3Fh space
	always_comb begin
		a      = req_in.addr;
		acc_ok = req_in.addr < ulc_pkg::ADDR_IMM_LIMIT;
		wr     = req_in.wr & acc_ok;
		rd     = req_in.rd & acc_ok;
		wd     = req_in.wdata;
	end

	// either enable bit arms the conversion interrupt
	assign irq_en_eff = ck_conv_irq_enable_r | resistor_conv_irq_enable_r;

	// register views as the link reads them
	always_comb begin
		conv_view = 8'h00;
		conv_view[ulc_pkg::CONV_CODE_LSB +: 3]  = id_resistor_code_r;
		conv_view[ulc_pkg::CONV_DONE_BIT]       = resistor_conv_done_r;
		conv_view[ulc_pkg::CONV_START_BIT]      = resistor_conv_trigger_r;
		conv_view[ulc_pkg::CONV_RSVD_BIT]       = conv_rsvd_r;
		conv_view[ulc_pkg::CONV_IEN_BIT]        = resistor_conv_irq_enable_r;
		ien_view = 8'h00;
		ien_view[ulc_pkg::CK_IEN_RISE_BIT]      = ident_open_rise_enable_r;
		ien_view[ulc_pkg::CK_IEN_FALL_BIT]      = ident_open_fall_enable_r;
		ien_view[ulc_pkg::CK_IEN_CONV_BIT]      = ck_conv_irq_enable_r;
	end

	// write, set and clear forms of the conversion register
	always_comb begin
		conv_nxt = conv_view;
		if (wr) begin
			case (a)
				ulc_pkg::ADDR_CONV_WR: begin
					conv_nxt = (conv_view & ~ulc_pkg::CONV_WMASK) | (wd & ulc_pkg::CONV_WMASK);
				end
				ulc_pkg::ADDR_CONV_SET: begin
					conv_nxt = conv_view | (wd & ulc_pkg::CONV_WMASK);
				end
				ulc_pkg::ADDR_CONV_CLR: begin
					conv_nxt = conv_view & ~(wd & ulc_pkg::CONV_WMASK);
				end
				default: begin
					conv_nxt = conv_view;
				end
			endcase
		end
	end

	// write, set and clear forms of the carkit enable register
	always_comb begin
		ien_nxt = ien_view;
		if (wr) begin
			case (a)
				ulc_pkg::ADDR_CK_IEN_WR: begin
					ien_nxt = wd & ulc_pkg::CK_IEN_MASK;
				end
				ulc_pkg::ADDR_CK_IEN_SET: begin
					ien_nxt = ien_view | (wd & ulc_pkg::CK_IEN_MASK);
				end
				ulc_pkg::ADDR_CK_IEN_CLR: begin
					ien_nxt = ien_view & ~(wd & ulc_pkg::CK_IEN_MASK);
				end
				default: begin
					ien_nxt = ien_view;
				end
			endcase
		end
	end

	// a trigger written while a conversion runs is stored but starts nothing;
	// the sequencer finishes the running one and then clears the bit
	// conversion kicks off on a 0 to 1 of the trigger bit by write or set
	assign conv_start = ~resistor_conv_trigger_r & conv_nxt[ulc_pkg::CONV_START_BIT];

	// conversion sequencer
	ulc_conv_timer #(
		.CYCLES     (CONV_CYCLES)
	) u_conv (
		.ref_clk_in (ref_clk_in),
		.arst_n_in  (arst_n_in),
		.start_in   (conv_start),
		.code_in    (id_resistor_code_in),
		.sample_out (conv_run),
		.done_out   (conv_done_pulse),
		.code_out   (conv_code)
	);

	// the done flag shares the pin's detector: a flag still set when a
	// second conversion ends gives no new event, so the link must read it
	// edges of ID float and of the done flag
	ulc_edge_detect #(
		.WIDTH      (2)
	) u_edges (
		.ref_clk_in (ref_clk_in),
		.arst_n_in  (arst_n_in),
		.level_in   ({resistor_conv_done_r, ident_open_in}),
		.rise_out   (rise),
		.fall_out   (fall)
	);

	// float event with either direction armed
	assign float_evt = (rise[0] & ident_open_rise_enable_r) |
	                   (fall[0] & ident_open_fall_enable_r);
	// done flag went 0 to 1 while armed
	assign conv_evt  = rise[1] & irq_en_eff;

	// carkit interrupt enable register
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ident_open_rise_enable_r <= 1'b0;
			ident_open_fall_enable_r <= 1'b0;
			ck_conv_irq_enable_r     <= 1'b0;
		end else begin
			ident_open_rise_enable_r <= ien_nxt[ulc_pkg::CK_IEN_RISE_BIT];
			ident_open_fall_enable_r <= ien_nxt[ulc_pkg::CK_IEN_FALL_BIT];
			ck_conv_irq_enable_r     <= ien_nxt[ulc_pkg::CK_IEN_CONV_BIT];
		end
	end

	// conversion register: link fields, plus hardware updates at completion
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			id_resistor_code_r         <= ulc_pkg::CONV_RESET[2:0];
			resistor_conv_trigger_r    <= 1'b0;
			conv_rsvd_r                <= 1'b0;
			resistor_conv_irq_enable_r <= 1'b0;
		end else begin
			conv_rsvd_r                <= conv_nxt[ulc_pkg::CONV_RSVD_BIT];
			resistor_conv_irq_enable_r <= conv_nxt[ulc_pkg::CONV_IEN_BIT];
			// completion overrides a same-cycle link write of these fields
			if (conv_done_pulse) begin
				id_resistor_code_r      <= conv_code;
				resistor_conv_trigger_r <= 1'b0;
			end else begin
				id_resistor_code_r      <= conv_nxt[ulc_pkg::CONV_CODE_LSB +: 3];
				resistor_conv_trigger_r <= conv_nxt[ulc_pkg::CONV_START_BIT];
			end
		end
	end

	// done flag: completion sets, read through 36h-38h clears, set wins
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			resistor_conv_done_r <= 1'b0;
		end else if (conv_done_pulse) begin
			resistor_conv_done_r <= 1'b1;
		end else if (rd && (a >= ulc_pkg::ADDR_CONV_WR) && (a <= ulc_pkg::ADDR_CONV_CLR)) begin
			resistor_conv_done_r <= 1'b0;
		end
	end

	// event latch: a read of 21h clears, a same-cycle event stays
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ident_open_event_latch_r    <= 1'b0;
			resistor_conv_event_latch_r <= 1'b0;
		end else begin
			if (float_evt) begin
				ident_open_event_latch_r <= 1'b1;
			end else if (rd && (a == ulc_pkg::ADDR_EVT_LATCH)) begin
				ident_open_event_latch_r <= 1'b0;
			end
			if (conv_evt) begin
				resistor_conv_event_latch_r <= 1'b1;
			end else if (rd && (a == ulc_pkg::ADDR_EVT_LATCH)) begin
				resistor_conv_event_latch_r <= 1'b0;
			end
		end
	end

	// vendor control registers, plain read/write
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hs_tx_drive_boost_r       <= ulc_pkg::BOOST_RESET;
			headset_audio_key_r <= ulc_pkg::HEADSET_KEY_RESET;
		end else if (wr) begin
			if (a == ulc_pkg::ADDR_HS_BOOST) begin
				hs_tx_drive_boost_r <= wd[ulc_pkg::BOOST_LSB +: 2];
			end
			if (a == ulc_pkg::ADDR_HEADSET_KEY) begin
				headset_audio_key_r <= wd[3:0];
			end
		end
	end

	// read multiplexer; unimplemented and reserved bits stay zero except the stored conversion bit 5
	always_comb begin
		rdata_nxt = 8'h00;
		hit_nxt   = 1'b1;
		case (a)
			ulc_pkg::ADDR_CK_IEN_WR, ulc_pkg::ADDR_CK_IEN_SET, ulc_pkg::ADDR_CK_IEN_CLR: begin
				rdata_nxt = ien_view;
			end
			ulc_pkg::ADDR_CK_STATUS: begin
				// status read shows the done flag but never clears it
				rdata_nxt[ulc_pkg::CK_ST_FLOAT_BIT]     = ident_open_in;
				rdata_nxt[ulc_pkg::CK_ST_CODE_LSB +: 3] = id_resistor_code_r;
				rdata_nxt[ulc_pkg::CK_ST_DONE_BIT]      = resistor_conv_done_r;
			end
			ulc_pkg::ADDR_EVT_LATCH: begin
				rdata_nxt[ulc_pkg::LATCH_FLOAT_BIT] = ident_open_event_latch_r;
				rdata_nxt[ulc_pkg::LATCH_CONV_BIT]  = resistor_conv_event_latch_r;
			end
			ulc_pkg::ADDR_HS_BOOST: begin
				rdata_nxt[ulc_pkg::BOOST_LSB +: 2] = hs_tx_drive_boost_r;
			end
			ulc_pkg::ADDR_HEADSET_KEY: begin
				rdata_nxt[3:0] = headset_audio_key_r;
			end
			ulc_pkg::ADDR_CONV_WR, ulc_pkg::ADDR_CONV_SET, ulc_pkg::ADDR_CONV_CLR: begin
				rdata_nxt = conv_view;
			end
			default: begin
				hit_nxt = 1'b0; // left to the rest of the register space
			end
		endcase
	end

	// registered answer keeps read data off the address decode path;
	// the link sees valid exactly one cycle after its read strobe
	// read answer one cycle after the request
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rsp_out <= '0;
		end else begin
			rsp_out.valid <= rd;
			rsp_out.hit   <= rd & hit_nxt;
			rsp_out.data  <= rd ? rdata_nxt : 8'h00;
		end
	end

	// registering the analog controls keeps decode glitches off the drivers,
	// at the cost of one cycle between a write and the new setting
	// outputs to the analog side and the RXCMD builder
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			alt_int_out          <= 1'b0;
			hs_tx_drive_boost_out      <= ulc_pkg::BOOST_RESET;
			headset_audio_en_out <= 1'b0;
			conv_active_out      <= 1'b0;
		end else begin
			alt_int_out          <= float_evt | conv_evt;
			hs_tx_drive_boost_out      <= hs_tx_drive_boost_r;
			headset_audio_en_out <= headset_audio_key_r == ulc_pkg::HEADSET_KEY_OPEN;
			conv_active_out      <= conv_run;
		end
	end
endmodule
`default_nettype wire

//--- inc/ulc_pkg.sv
// constants and carrier types for the transceiver vendor and carkit register bank
// Function
// - ID float edges set latch bit 0
// - latch reads only, auto-clears after read
// - latch bits 1,2 and upper always zero
// - conversion-done rise with enable sets latch bit 3
// - immediate and extended addressing reach same registers
// - vendor registers 30h-3Fh use immediate transfers
// - boost bits 6:5 choose transmit amplitude
// - headset audio only while key equals 1010
// - result bits 2:0 encode ID resistance
// - done flag bit 3 after 282 us conversion
// - result read via 36h-38h clears done flag
// - start bit 4 begins conversion, self-clears
// - enabled done assertion raises alt_int
// - effective enable ORs both enable bits
// - conversion register write/set/clear at 36h/37h/38h
// - carkit enable register at 1Dh/1Eh/1Fh
`default_nettype none
package ulc_pkg;
	// register addresses (immediate space)
	localparam logic [7:0] ADDR_CK_IEN_WR   = 8'h1d;
	localparam logic [7:0] ADDR_CK_IEN_SET  = 8'h1e;
	localparam logic [7:0] ADDR_CK_IEN_CLR  = 8'h1f;
	localparam logic [7:0] ADDR_CK_STATUS   = 8'h20;
	localparam logic [7:0] ADDR_EVT_LATCH   = 8'h21;
	localparam logic [7:0] ADDR_VENDOR_LO   = 8'h30;
	localparam logic [7:0] ADDR_VENDOR_HI   = 8'h3f;
	localparam logic [7:0] ADDR_HS_BOOST    = 8'h31;
	localparam logic [7:0] ADDR_HEADSET_KEY = 8'h33;
	localparam logic [7:0] ADDR_CONV_WR     = 8'h36;
	localparam logic [7:0] ADDR_CONV_SET    = 8'h37;
	localparam logic [7:0] ADDR_CONV_CLR    = 8'h38;
	localparam logic [7:0] ADDR_IMM_LIMIT   = 8'h40;
	// carkit interrupt enable fields
	localparam int CK_IEN_RISE_BIT = 0;
	localparam int CK_IEN_FALL_BIT = 1;
	localparam int CK_IEN_CONV_BIT = 5;
	localparam logic [7:0] CK_IEN_MASK = 8'h23;
	// carkit status fields
	localparam int CK_ST_FLOAT_BIT = 0;
	localparam int CK_ST_CODE_LSB  = 3;
	localparam int CK_ST_DONE_BIT  = 6;
	// event latch fields
	localparam int LATCH_FLOAT_BIT = 0;
	localparam int LATCH_CONV_BIT  = 3;
	// boost fields
	localparam int BOOST_LSB = 5;
	localparam logic [1:0] BOOST_RESET = 2'h0;
	// headset key
	localparam logic [3:0] HEADSET_KEY_OPEN  = 4'ha;
	localparam logic [3:0] HEADSET_KEY_RESET = 4'h0;
	// conversion register fields
	localparam int CONV_CODE_LSB   = 0;
	localparam int CONV_DONE_BIT   = 3;
	localparam int CONV_START_BIT  = 4;
	localparam int CONV_RSVD_BIT   = 5;
	localparam int CONV_IEN_BIT    = 6;
	localparam logic [7:0] CONV_WMASK = 8'h77;
	localparam logic [7:0] CONV_RESET = 8'h00;
	// resistance codes
	localparam logic [2:0] RID_ZERO    = 3'h0;
	localparam logic [2:0] RID_75      = 3'h1;
	localparam logic [2:0] RID_100K    = 3'h2;
	localparam logic [2:0] RID_200K    = 3'h3;
	localparam logic [2:0] RID_440K    = 3'h4;
	localparam logic [2:0] RID_FLOAT   = 3'h5;
	localparam logic [2:0] RID_ERROR   = 3'h7;
	// conversion timing
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int CONV_TIME_US   = 282;
	localparam int CONV_CYCLES    = (CONV_TIME_US * 1000000) / CLK_PERIOD_PS;
	// register access request from the link-side protocol engine
	typedef struct packed {
		logic       ext;   // address arrived by extended sequence
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ulc_req_t;
	// read answer
	typedef struct packed {
		logic       valid;
		logic       hit;
		logic [7:0] data;
	} ulc_rsp_t;
endpackage
`default_nettype wire

//--- verilog/ulc_edge_detect.sv
// per-bit rising and falling edge detector on synchronous levels
`default_nettype none
module ulc_edge_detect #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             arst_n_in,
	// levels
	input  wire logic [WIDTH-1:0] level_in,
	// edges, one-cycle pulses
	output logic      [WIDTH-1:0] rise_out,
	output logic      [WIDTH-1:0] fall_out
);
	logic [WIDTH-1:0] prev_r; // level one cycle ago

	// one identical detector per bit
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		// remember last level; reset to zero so a high level at release reads as a rise
		always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				prev_r[i] <= 1'b0;
			end else begin
				prev_r[i] <= level_in[i];
			end
		end
		assign rise_out[i] = level_in[i] & ~prev_r[i];
		assign fall_out[i] = ~level_in[i] & prev_r[i];
	end
endmodule
`default_nettype wire

//--- verilog/ulc_conv_timer.sv
// ID resistor conversion sequencer: times the conversion and captures the code
`default_nettype none
module ulc_conv_timer #(
	parameter int CYCLES = ulc_pkg::CONV_CYCLES
) (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       arst_n_in,
	// control
	input  wire logic       start_in,    // pulse, ignored while busy
	// analog converter
	input  wire logic [2:0] code_in,     // converter output, valid at the end
	output logic            sample_out,  // level, converter active
	// results
	output logic            done_out,    // pulse at completion
	output logic [2:0]      code_out     // code captured at completion
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	typedef enum logic {ULC_IDLE, ULC_RUN} ulc_state_t;
	ulc_state_t  state_r;   // sequencer state
	logic [CW-1:0] cnt_r;   // cycles spent converting

	// a retrigger while running is dropped, the link sees one completion
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= ULC_IDLE;
			cnt_r   <= '0;
		end else begin
			case (state_r)
				ULC_IDLE: begin
					cnt_r <= '0;
					if (start_in) begin
						state_r <= ULC_RUN;
					end
				end
				ULC_RUN: begin
					if (cnt_r == LAST) begin
						state_r <= ULC_IDLE;
					end
					cnt_r <= cnt_r + CW'(1);
				end
				default: begin
					state_r <= ULC_IDLE;
				end
			endcase
		end
	end

	// completion pulse and captured code
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			done_out <= 1'b0;
			code_out <= ulc_pkg::RID_ZERO;
		end else begin
			done_out <= (state_r == ULC_RUN) && (cnt_r == LAST);
			if ((state_r == ULC_RUN) && (cnt_r == LAST)) begin
				code_out <= code_in;
			end
		end
	end

	assign sample_out = (state_r == ULC_RUN);
endmodule
`default_nettype wire

//--- bench/ulc_regs_properties.sv
// port assertions for the vendor and carkit register bank
`default_nettype none
module ulc_regs_checker #(
	parameter int CONV_CYCLES = ulc_pkg::CONV_CYCLES
) (
	// clock and reset
	input wire logic              ref_clk_in,
	input wire logic              arst_n_in,
	// register port
	input wire ulc_pkg::ulc_req_t req_in,
	input wire ulc_pkg::ulc_rsp_t rsp_out,
	// converter and analog controls
	input wire logic              conv_active_out,
	input wire logic [1:0]        hs_tx_drive_boost_out,
	input wire logic              headset_audio_en_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	int unsigned active_cnt_r; // cycles the converter has been busy
	// busy run length, restarts whenever the converter goes idle
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			active_cnt_r <= 0;
		else if (conv_active_out)
			active_cnt_r <= active_cnt_r + 1;
		else
			active_cnt_r <= 0;
	end
	property p_rd_answer;
		req_in.rd && req_in.addr < 8'h40 |=> rsp_out.valid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read inside the immediate range got no answer");
	property p_no_answer;
		!(req_in.rd && req_in.addr < 8'h40) |=> !rsp_out.valid;
	endproperty
	a_no_answer: assert property (p_no_answer)
		else $error("answer without a matching read");
	property p_unmapped;
		rsp_out.valid && !rsp_out.hit |-> rsp_out.data == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("foreign address returned data");
	property p_latch_rsvd;
		rsp_out.valid && $past(req_in.addr) == 8'h21 |-> rsp_out.data[7:4] == 4'h0
			&& rsp_out.data[2:1] == 2'h0;
	endproperty
	a_latch_rsvd: assert property (p_latch_rsvd)
		else $error("unused latch bits read nonzero");
	property p_conv_rsvd;
		rsp_out.valid && $past(req_in.addr) inside {8'h36, 8'h37, 8'h38}
			|-> rsp_out.data[7] == 1'b0;
	endproperty
	a_conv_rsvd: assert property (p_conv_rsvd)
		else $error("conversion register bit 7 read nonzero");
	property p_boost_read;
		rsp_out.valid && $past(req_in.addr) == 8'h31 && !$past(req_in.wr)
			|-> rsp_out.data == {1'b0, hs_tx_drive_boost_out, 5'h00};
	endproperty
	a_boost_read: assert property (p_boost_read)
		else $error("boost readback disagrees with drive output");
	// register stage plus output stage: the drive pins follow two edges after the write
	property p_boost_write;
		req_in.wr && req_in.addr == 8'h31
			|=> ##1 hs_tx_drive_boost_out == $past(req_in.wdata[6:5], 2);
	endproperty
	a_boost_write: assert property (p_boost_write)
		else $error("boost write did not reach the drive output");
	property p_key_out;
		rsp_out.valid && $past(req_in.addr) == 8'h33 && !$past(req_in.wr)
			|-> rsp_out.data[7:4] == 4'h0 && headset_audio_en_out == (rsp_out.data[3:0] == 4'ha);
	endproperty
	a_key_out: assert property (p_key_out)
		else $error("headset enable disagrees with key field");
	property p_conv_bound;
		active_cnt_r <= CONV_CYCLES + 1;
	endproperty
	a_conv_bound: assert property (p_conv_bound)
		else $error("conversion ran too long");
	property p_conv_len;
		$fell(conv_active_out) |-> active_cnt_r + 1 >= CONV_CYCLES
			&& active_cnt_r <= CONV_CYCLES + 1;
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("conversion ended at the wrong time");
endmodule
bind ulc_regs ulc_regs_checker #(.CONV_CYCLES(CONV_CYCLES)) ulc_regs_checker_inst (
	.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .req_in(req_in), .rsp_out(rsp_out),
	.conv_active_out(conv_active_out), .hs_tx_drive_boost_out(hs_tx_drive_boost_out),
	.headset_audio_en_out(headset_audio_en_out));
`default_nettype wire

//--- bench/ulc_link_model.sv
// link controller model issuing immediate register reads and writes
`default_nettype none
module ulc_link_model (
	// clock
	input  wire logic              ref_clk_in,
	// register port
	output var ulc_pkg::ulc_req_t  req_out,
	input  wire ulc_pkg::ulc_rsp_t rsp_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req_out = '0;
	// one-cycle write strobe, launched and dropped on falling edges
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_in);
		req_out.addr = a;
		// bit 5 of the conversion register must stay zero
		req_out.wdata = (a inside {8'h36, 8'h37}) ? (d & 8'hdf) : d;
		req_out.wr = 1'b1;
		@(negedge ref_clk_in);
		req_out.wr = 1'b0;
	endtask
	// one-cycle read strobe, answer taken the cycle after
	task automatic reg_read(input logic [7:0] a, output ulc_pkg::ulc_rsp_t r);
		@(negedge ref_clk_in);
		req_out.addr = a;
		req_out.rd = 1'b1;
		@(negedge ref_clk_in);
		req_out.rd = 1'b0;
		r = rsp_in;
	endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the vendor and carkit register bank
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %0t got %h expected %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CONV = 20;              // shortened conversion length
	logic              ref_clk_in;
	logic              arst_n_in;
	ulc_pkg::ulc_req_t req;
	ulc_pkg::ulc_rsp_t rsp;
	logic              ident_open;         // ID pin floating
	logic [2:0]        code;               // converter result
	logic              conv_active;
	logic              alt_int;
	logic [1:0]        boost;
	logic              headset_en;
	int                mismatches = 0;
	int                comparisons = 0;
	int                alt_cnt = 0;        // alt_int pulses seen
	int                cycles = 0;
	ulc_pkg::ulc_rsp_t r;
	logic [2:0]        codes[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
	ulc_regs #(.CONV_CYCLES(CONV)) ulc_regs_inst (
		.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .req_in(req), .rsp_out(rsp),
		.ident_open_in(ident_open), .id_resistor_code_in(code),
		.conv_active_out(conv_active), .alt_int_out(alt_int),
		.hs_tx_drive_boost_out(boost), .headset_audio_en_out(headset_en));
	ulc_link_model ulc_link_model_inst (.ref_clk_in(ref_clk_in), .req_out(req), .rsp_in(rsp));
	// free-running clock
	always #2.5 ref_clk_in = ~ref_clk_in;
	// hang guard and interrupt pulse counter
	always @(posedge ref_clk_in) begin
		cycles++;
		if (alt_int === 1'b1)
			alt_cnt++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ulc_link_model_inst.reg_write(a, d);
	endtask
	// read an owned register and compare its value
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		ulc_pkg::ulc_rsp_t rr;
		ulc_link_model_inst.reg_read(a, rr);
		`CHK({rr.valid, rr.hit, rr.data}, {2'b11, e})
	endtask
	// start a conversion and wait out its fixed length
	task automatic conv(input logic [2:0] c, input logic [7:0] d);
		code = c;
		wr(8'h36, d);
		repeat (CONV + 4) @(negedge ref_clk_in);
	endtask
	initial begin
		ref_clk_in = 1'b0;
		arst_n_in = 1'b0;
		ident_open = 1'b0;
		code = 3'h0;
		repeat (6) @(negedge ref_clk_in);
		arst_n_in = 1'b1;
		// reset values
		rd_chk(8'h31, 8'h00);
		rd_chk(8'h33, 8'h00);
		rd_chk(8'h36, 8'h00);
		rd_chk(8'h21, 8'h00);
		rd_chk(8'h1d, 8'h00);
		// unowned vendor address, then beyond the immediate range
		ulc_link_model_inst.reg_read(8'h3a, r);
		`CHK({r.valid, r.hit, r.data}, 10'h200)
		ulc_link_model_inst.reg_read(8'h40, r);
		`CHK(r.valid, 1'b0)
		// every drive setting, reserved bits written as ones
		for (int i = 0; i < 4; i++) begin
			wr(8'h31, {1'b1, 2'(i), 5'h1f});
			rd_chk(8'h31, {1'b0, 2'(i), 5'h00});
			`CHK(boost, 2'(i))
		end
		// key opens audio only on the exact pattern
		wr(8'h33, 8'h5a);
		rd_chk(8'h33, 8'h0a);
		`CHK(headset_en, 1'b1)
		wr(8'h33, 8'h0b);
		@(negedge ref_clk_in); // enable output lags the key by one register
		`CHK(headset_en, 1'b0)
		// float edges against the two enables
		wr(8'h1d, 8'h01);
		ident_open = 1'b1;
		repeat (3) @(negedge ref_clk_in);
		`CHK(alt_cnt, 1)
		rd_chk(8'h21, 8'h01);
		rd_chk(8'h21, 8'h00);
		wr(8'h1e, 8'h02);
		wr(8'h1f, 8'h01);
		rd_chk(8'h1d, 8'h02);
		ident_open = 1'b0;
		repeat (3) @(negedge ref_clk_in);
		rd_chk(8'h21, 8'h01);
		ident_open = 1'b1;
		repeat (3) @(negedge ref_clk_in);
		rd_chk(8'h21, 8'h00);
		// every result code, no conversion interrupt enabled
		foreach (codes[k]) begin
			conv(codes[k], 8'h10);
			rd_chk(8'h20, {2'b01, codes[k], 3'h1});
			rd_chk(8'h36, {5'h01, codes[k]});
			rd_chk(8'h38, {5'h00, codes[k]});
		end
		`CHK(alt_cnt, 2)
		// carkit side enable alone
		wr(8'h1e, 8'h20);
		conv(3'h2, 8'h10);
		rd_chk(8'h21, 8'h08);
		`CHK(alt_cnt, 3)
		rd_chk(8'h36, 8'h0a);
		// conversion register enable alone
		wr(8'h1f, 8'h20);
		conv(3'h4, 8'h50);
		rd_chk(8'h37, 8'h4c);
		rd_chk(8'h21, 8'h08);
		`CHK(alt_cnt, 4)
		wr(8'h38, 8'h40);
		rd_chk(8'h36, 8'h04);
		complete_run();
	end
endmodule
`default_nettype wire
